// [pkg/otg_port_pkg.sv]
package otg_port_pkg;
  // Register index and command codes of the control word
  localparam logic [7:0]  CTRL_INDEX      = 8'h62;
  localparam logic [7:0]  CTRL_WRITE_CODE = 8'hE2;
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  CTRL_BYTE_ADDR  = {CTRL_INDEX, 2'b00};
  // Field positions
  localparam int BIT_BUS_POWER_DRIVE   = 0;
  localparam int BIT_LOCAL_PULLUP      = 4;
  localparam int BIT_AUTO_PULLUP_EN    = 5;
  localparam int BIT_PLUS_PULLDOWN     = 6;
  localparam int BIT_MINUS_PULLDOWN    = 7;
  localparam int BIT_ENGINE_ROUTE      = 8;
  localparam int BIT_SESSION_METHOD    = 9;
  localparam int BIT_SESSION_DETECT_EN = 10;
  localparam int BIT_RESET_ON_CONNECT  = 11;
  // Reset value and writable bits
  localparam logic [15:0] CTRL_RESET      = 16'h01C0;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h0FFF;
  // Bus reset length driven on remote connect
  localparam int CLK_MHZ         = 40;
  localparam int BUS_RESET_US    = 10000;
  localparam int BUS_RESET_CYCLES = BUS_RESET_US * CLK_MHZ;
  localparam int RESET_CNT_W     = 20;
  // Synchronised line inputs
  localparam int SYNC_N   = 4;
  localparam int IN_RCONN = 0;
  localparam int IN_VBUSP = 1;
  localparam int IN_DATAP = 2;
  localparam int IN_ID    = 3;

  // Pad control bundle towards the transceiver
  typedef struct packed {
    logic engine_route_sel;
    logic minus_line_pulldown;
    logic plus_line_pulldown;
    logic dp_pullup;
    logic bus_power_drive_en;
    logic se0_drive;
  } pad_ctrl_t;

  // Bus reset sequencer
  typedef enum logic [1:0] {
    RST_IDLE  = 2'b01,
    RST_DRIVE = 2'b10
  } reset_state_t;
endpackage

// [core/otg_port_control_register.sv]
`timescale 1ns/10ps
// How it works
// - Read code 62h, write code E2h, 16 bits; the code takes writes at index 62h too, CTRL_WRITE_CODE is unused
// - Bit 11 set: send SE0 on remote connect
// - Bit 10 enables session request flag, A-device
// - Bit 9 picks VBUS or data pulsing
// - Bit 8 routes host or peripheral engine
// - Bit 7 connects minus line pull-down
// - Bit 6 connects plus line pull-down
// - Bit 5 auto pull-up on remote disconnect, A-device
// - Bit 4 connects plus line pull-up
// - Bit 0 drives VBUS, never for B-device; the pin follows the bit whatever the role
module otg_port_control_register
  import otg_port_pkg::*;
#(
  parameter int RESET_CYCLES = BUS_RESET_CYCLES  // Bus reset length in cycles
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              remote_pullup_seen,
  input  wire logic              vbus_pulse_seen,
  input  wire logic              data_pulse_seen,
  input  wire logic              id_pin,
  input  wire logic              session_req_flag_clear,
  output logic                   session_req_detected_flag,
  output pad_ctrl_t              pads
);

  logic [15:0]       otg_port_control;  // The control word
  logic              ack;               // Answer phase of a bus access
  logic [SYNC_N-1:0] sync1;             // First stage, read only by sync2
  logic [SYNC_N-1:0] sync2;
  logic [SYNC_N-1:0] sync3;
  logic [SYNC_N-1:0] line;              // Debounced line levels
  logic [SYNC_N-1:0] line_d;            // Previous debounced levels
  logic              auto_pullup;       // Pull-up latched by a disconnect
  reset_state_t      reset_state;
  logic [RESET_CNT_W-1:0] reset_cnt;

  // Address decode and strobes
  wire        hit        = (address == CTRL_BYTE_ADDR);
  wire        req        = read | write;
  wire        do_write   = write & ack & hit;
  wire [15:0] lane_mask  = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [15:0] wr_mask    = lane_mask & CTRL_WRITE_MASK;
  wire [15:0] next_ctrl  = (otg_port_control & ~wr_mask) | (writedata[15:0] & wr_mask);

  // Line events, A-device when the ID pin reads low
  wire is_a_device  = ~line[IN_ID];
  wire connect_evt  = line[IN_RCONN] & ~line_d[IN_RCONN];
  wire discon_evt   = ~line[IN_RCONN] & line_d[IN_RCONN];
  wire vbus_evt     = line[IN_VBUSP] & ~line_d[IN_VBUSP];
  wire data_evt     = line[IN_DATAP] & ~line_d[IN_DATAP];
  wire srp_evt      = otg_port_control[BIT_SESSION_METHOD] ? data_evt : vbus_evt;
  wire srp_set      = is_a_device & otg_port_control[BIT_SESSION_DETECT_EN] & srp_evt;
  wire rst_start    = otg_port_control[BIT_RESET_ON_CONNECT] & connect_evt;
  wire auto_set     = is_a_device & otg_port_control[BIT_AUTO_PULLUP_EN] & discon_evt;
  wire last_rst_cyc = (reset_cnt == RESET_CNT_W'(RESET_CYCLES - 1));

  // One wait cycle, then answer; the request is held until then
  assign waitrequest = req & ~ack;

  // Answer phase follows every request by one cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Control word; only a write strobe that hits CTRL_BYTE_ADDR stores it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      otg_port_control <= CTRL_RESET;
    end else if (do_write) begin
      otg_port_control <= next_ctrl;
    end
  end

  // Read data, zero for unmapped addresses and reserved bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h00000000;
    end else if (read & ~ack) begin
      readdata <= hit ? {16'h0000, otg_port_control & CTRL_WRITE_MASK} : 32'h00000000;
    end
  end

  // Three flop synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          // Idle levels; the role line starts as B-device so no false A-device follows reset
          sync1[gi]  <= (gi == IN_ID);
          sync2[gi]  <= (gi == IN_ID);
          sync3[gi]  <= (gi == IN_ID);
          line[gi]   <= (gi == IN_ID);
          line_d[gi] <= (gi == IN_ID);
        end else begin
          sync1[gi]  <= gi == IN_RCONN ? remote_pullup_seen :
                        gi == IN_VBUSP ? vbus_pulse_seen :
                        gi == IN_DATAP ? data_pulse_seen : id_pin;
          sync2[gi]  <= sync1[gi];
          sync3[gi]  <= sync2[gi];
          line[gi]   <= (sync2[gi] == sync3[gi]) ? sync3[gi] : line[gi];
          line_d[gi] <= line[gi];
        end
      end
    end
  endgenerate

  // Sticky session request flag; a new event wins over the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      session_req_detected_flag <= 1'b0;
    end else if (srp_set) begin
      session_req_detected_flag <= 1'b1;
    end else if (session_req_flag_clear) begin
      session_req_detected_flag <= 1'b0;
    end
  end

  // Auto pull-up holds until software drops the enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      auto_pullup <= 1'b0;
    end else if (auto_set) begin
      auto_pullup <= 1'b1;
    end else if (!otg_port_control[BIT_AUTO_PULLUP_EN]) begin
      auto_pullup <= 1'b0;  // Software sets local connect first
    end
  end

  // Bus reset sequencer: drive SE0 for a fixed time after a connect
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_state <= RST_IDLE;
      reset_cnt   <= '0;
    end else begin
      case (reset_state)
        RST_IDLE: begin
          reset_cnt <= '0;
          if (rst_start) begin
            reset_state <= RST_DRIVE;
          end
        end
        RST_DRIVE: begin
          reset_cnt <= reset_cnt + 1'b1;
          if (last_rst_cyc) begin
            reset_state <= RST_IDLE;
          end
        end
        default: begin
          reset_state <= RST_IDLE;
        end
      endcase
    end
  end

  // Pad controls come from flops, dp_pullup through an OR and se0_drive through a state compare, gathered in one driver of the bundle
  assign pads = '{
    engine_route_sel:    otg_port_control[BIT_ENGINE_ROUTE],
    minus_line_pulldown: otg_port_control[BIT_MINUS_PULLDOWN],
    plus_line_pulldown:  otg_port_control[BIT_PLUS_PULLDOWN],
    dp_pullup:           otg_port_control[BIT_LOCAL_PULLUP] | auto_pullup,
    // Software keeps this clear as a B-device; the pin only follows the bit
    bus_power_drive_en:  otg_port_control[BIT_BUS_POWER_DRIVE],
    se0_drive:           (reset_state == RST_DRIVE)  // High for the whole bus reset
  };

  // Checks
  AST_WRITE_STORES: assert property (@(posedge ref_clk) disable iff (!rstn)
    do_write && (byteenable[1:0] == 2'b11)
    |=> {16'h0000, otg_port_control} == ($past(writedata) & {16'h0000, CTRL_WRITE_MASK}))
    else $error("Control write not stored");
  AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (!rstn)
    read && hit && !ack |=> !waitrequest && readdata[15:0] == (otg_port_control & CTRL_WRITE_MASK))
    else $error("Control read wrong");
  AST_SE0_ON_CONNECT: assert property (@(posedge ref_clk) disable iff (!rstn)
    rst_start && reset_state == RST_IDLE |=> pads.se0_drive [*8])
    else $error("SE0 not driven on connect");
  AST_NO_SE0_WHEN_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    !pads.se0_drive && !otg_port_control[BIT_RESET_ON_CONNECT] |=> !pads.se0_drive)
    else $error("SE0 driven without enable");
  AST_SRP_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
    srp_set |=> session_req_detected_flag)
    else $error("Session request flag missed");
  AST_SRP_GATED: assert property (@(posedge ref_clk) disable iff (!rstn)
    !session_req_detected_flag && !otg_port_control[BIT_SESSION_DETECT_EN]
    |=> !session_req_detected_flag)
    else $error("Flag set while disabled");
  AST_SRP_METHOD: assert property (@(posedge ref_clk) disable iff (!rstn)
    !session_req_detected_flag && !session_req_flag_clear && data_evt && !vbus_evt
    && !otg_port_control[BIT_SESSION_METHOD] |=> !session_req_detected_flag)
    else $error("Wrong detection method");
  AST_PULLUP: assert property (@(posedge ref_clk) disable iff (!rstn)
    auto_set |=> pads.dp_pullup)
    else $error("Auto pull-up not applied");
  AST_PULLUP_LOCAL: assert property (@(posedge ref_clk) disable iff (!rstn)
    !otg_port_control[BIT_AUTO_PULLUP_EN] && !$past(otg_port_control[BIT_AUTO_PULLUP_EN])
    |-> pads.dp_pullup == otg_port_control[BIT_LOCAL_PULLUP])
    else $error("Pull-up not following local bit");
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    readdata[31:12] == 20'h00000)
    else $error("Reserved bits nonzero");
  COV_WRITE: cover property (@(posedge ref_clk) disable iff (!rstn) do_write);
  COV_BUS_RESET: cover property (@(posedge ref_clk) disable iff (!rstn) rst_start);
  COV_SRP: cover property (@(posedge ref_clk) disable iff (!rstn) srp_set);
  COV_AUTO: cover property (@(posedge ref_clk) disable iff (!rstn) auto_set);
  COV_SE0_DONE: cover property (@(posedge ref_clk) disable iff (!rstn) last_rst_cyc && pads.se0_drive);

endmodule // otg_port_control_register

// [sim/otg_peer_model.sv]
`timescale 1ns/10ps
// Far-side peer: drives the cable lines, changing them only after a clock edge
module otg_peer_model (
  input  wire logic ref_clk,
  output logic      remote_pullup_seen,
  output logic      vbus_pulse_seen,
  output logic      data_pulse_seen,
  output logic      id_pin
);
  // Idle lines; id high makes the local side a B-device
  initial begin
    remote_pullup_seen = 1'b0;
    vbus_pulse_seen    = 1'b0;
    data_pulse_seen    = 1'b0;
    id_pin             = 1'b1;
  end
  // Attach or drop the peer pull-up
  task automatic conn(input logic v);
    @(posedge ref_clk);
    remote_pullup_seen <= v;
  endtask
  // Cable role of the local side
  task automatic role(input logic v);
    @(posedge ref_clk);
    id_pin <= v;
  endtask
  // Session request pulse, held 5 cycles so the line filter can see it
  task automatic srp(input logic on_data);
    @(posedge ref_clk);
    if (on_data) data_pulse_seen <= 1'b1;
    else vbus_pulse_seen <= 1'b1;
    repeat (5) @(posedge ref_clk);
    data_pulse_seen <= 1'b0;
    vbus_pulse_seen <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // otg_peer_model

// [sim/test_otg_port_control_register.sv]
`timescale 1ns/10ps
`define CHECK_EQ(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_otg_port_control_register;
  import otg_port_pkg::*;
  logic              ref_clk = 1'b0;  // 40 MHz
  logic              rstn;
  logic [ADDR_W-1:0] address;
  logic              read, write, flag_clr, flag;
  logic [31:0]       writedata, readdata, q;
  logic [3:0]        byteenable;
  logic              waitrequest, rconn, vbusp, datap, idp;
  pad_ctrl_t         pads;
  int                n_mismatch = 0, n_tests = 0, i, n;
  // Field patterns, reserved bits included
  logic [15:0]       pat [8] = '{16'hFFFF, 16'h0000, 16'h0100, 16'h0080,
                                 16'h0040, 16'h0010, 16'h0001, 16'hF0CF};
  always #12.5 ref_clk = ~ref_clk;
  otg_port_control_register #(.RESET_CYCLES(20)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .remote_pullup_seen(rconn), .vbus_pulse_seen(vbusp), .data_pulse_seen(datap),
    .id_pin(idp), .session_req_flag_clear(flag_clr), .session_req_detected_flag(flag),
    .pads(pads));
  otg_peer_model peer (.ref_clk(ref_clk), .remote_pullup_seen(rconn),
    .vbus_pulse_seen(vbusp), .data_pulse_seen(datap), .id_pin(idp));
  // Pads expected from the stored word while no auto pull-up is latched
  function automatic pad_ctrl_t exp_pads(input logic [15:0] d);
    return {d[8], d[7], d[6], d[4], d[0], 1'b0};
  endfunction
  // One Avalon access; request held until waitrequest is seen low
  task automatic acc(input logic is_wr, input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    read      <= !is_wr;
    write     <= is_wr;
    address   <= a;
    writedata <= {~d, d};
    // Sample waitrequest at each rising edge; data is taken at the edge it is low
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] d);
    acc(1'b1, CTRL_BYTE_ADDR, d);
  endtask
  task automatic rdchk(input logic [15:0] e);
    acc(1'b0, CTRL_BYTE_ADDR, 16'h0000);
    `CHECK_EQ(q, {16'h0000, e})
  endtask
  // Clear the sticky flag and confirm it dropped
  task automatic clr();
    @(posedge ref_clk);
    flag_clr <= 1'b1;
    @(posedge ref_clk);
    flag_clr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHECK_EQ(flag, 1'b0)
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, several times the expected run length
  initial begin
    #300000;
    n_mismatch++;
    summarize();
  end
  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    byteenable = 4'h3; flag_clr = 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    `CHECK_EQ(pads, pad_ctrl_t'(6'b111000))
    rdchk(16'h01C0);
    $display("reset test done");
    // Pad fields (bits 8, 7, 6, 4, 0) alone, plus all-ones, zero and a mix; reserved nibble must read back zero
    peer.role(1'b0);
    foreach (pat[k]) begin
      wr(pat[k]);
      rdchk(pat[k] & 16'h0FFF);
      `CHECK_EQ(pads, exp_pads(pat[k]))
    end
    // Unmapped word: write dropped, read zero
    acc(1'b1, 10'h189, 16'h0FFF);
    acc(1'b0, 10'h3F7, 16'h0000);
    `CHECK_EQ(q, 32'h0000_0000)
    rdchk(16'h00CF);
    $display("field test done");
    // Byte lanes: lanes 0 and 1 alone, lanes 3 and 2 together change nothing
    byteenable <= 4'h1;
    wr(16'hFA35);
    rdchk(16'h0035);
    byteenable <= 4'h2;
    wr(16'hFB00);
    rdchk(16'h0B35);
    byteenable <= 4'hC;
    wr(16'h0FFF);
    rdchk(16'h0B35);
    byteenable <= 4'hF;
    $display("byte lane test done");
    // Connect with bus reset disabled sends nothing
    wr(16'h01C0);
    peer.role(1'b1);
    peer.conn(1'b1);
    repeat (15) @(negedge ref_clk);
    `CHECK_EQ(pads.se0_drive, 1'b0)
    peer.conn(1'b0);
    repeat (2000) @(posedge ref_clk);
    wr(16'h09C0);
    wr(16'h08C0);
    peer.conn(1'b1);
    for (i = 0; i < 15 && pads.se0_drive !== 1'b1; i++) @(negedge ref_clk);
    for (n = 0; n < 100 && pads.se0_drive === 1'b1; n++) @(negedge ref_clk);
    `CHECK_EQ(n, 20)
    wr(16'h00C0);
    peer.conn(1'b0);
    $display("bus reset test done");
    // Session request as A-device, both methods and disabled
    peer.role(1'b0);
    wr(16'h04C0);
    peer.srp(1'b0);
    `CHECK_EQ(flag, 1'b1)
    clr();
    peer.srp(1'b1);
    `CHECK_EQ(flag, 1'b0)
    wr(16'h06C0);
    peer.srp(1'b1);
    `CHECK_EQ(flag, 1'b1)
    clr();
    peer.srp(1'b0);
    `CHECK_EQ(flag, 1'b0)
    wr(16'h02C0);
    peer.srp(1'b1);
    `CHECK_EQ(flag, 1'b0)
    // B-device with detection enabled sets no flag
    peer.role(1'b1);
    wr(16'h04C0);
    peer.srp(1'b0);
    `CHECK_EQ(flag, 1'b0)
    peer.role(1'b0);
    $display("session request test done");
    // Auto pull-up on remote disconnect, then safe hand-back to bit 4
    peer.conn(1'b1);
    repeat (12) @(posedge ref_clk);
    wr(16'h00E0);
    peer.conn(1'b0);
    repeat (12) @(negedge ref_clk);
    `CHECK_EQ(pads.dp_pullup, 1'b1)
    wr(16'h00F0);
    wr(16'h00D0);
    repeat (2) @(negedge ref_clk);
    `CHECK_EQ(pads.dp_pullup, 1'b1)
    wr(16'h00C0);
    @(negedge ref_clk);
    `CHECK_EQ(pads.dp_pullup, 1'b0)
    peer.conn(1'b1);
    repeat (12) @(posedge ref_clk);
    peer.conn(1'b0);
    repeat (12) @(negedge ref_clk);
    `CHECK_EQ(pads.dp_pullup, 1'b0)
    $display("auto pull-up test done");
    summarize();
  end
endmodule // test_otg_port_control_register
